// ### verilog/ics_params.svh
// constants for the internal clock source unit
`ifndef ICS_PARAMS_SVH
`define ICS_PARAMS_SVH
`define ICS_SYS_CLK_MHZ      200
`define ICS_SEL_LOOP         2'h0
`define ICS_SEL_INT          2'h1
`define ICS_SEL_EXT          2'h2
`define ICS_DIV_1            2'h0
`define ICS_IRC_BASE_HALF    10'h040
`define ICS_LOOP_SHIFT       3
`define ICS_LOOP_EXT_HALF    10'h010
`define ICS_HALF_MIN         10'h001
`define ICS_SWITCH_EDGES     3'h3
`define ICS_SWITCH_TIMEOUT_US 100
`define ICS_SWITCH_TIMEOUT_CYC (`ICS_SWITCH_TIMEOUT_US * `ICS_SYS_CLK_MHZ)
`endif

// ### verilog/ics_pkg.sv
// types shared by the internal clock source unit
package ics_pkg;
    typedef enum logic [2:0] {
        LOOP_ENGAGED_INTERNAL_MODE,
        LOOP_ENGAGED_EXTERNAL_MODE,
        LOOP_BYPASSED_INTERNAL_MODE,
        BYPASSED_INTERNAL_LOW_POWER_MODE,
        LOOP_BYPASSED_EXTERNAL_MODE,
        BYPASSED_EXTERNAL_LOW_POWER_MODE,
        STOP_MODE
    } ics_mode_type;

    typedef enum logic [1:0] {
        SRC_LOOP,
        SRC_INT,
        SRC_EXT
    } ics_src_type;

    // live levels of the three candidate clocks
    typedef struct packed {
        logic loop_lvl;
        logic int_lvl;
        logic ext_lvl;
    } ics_levels_type;
endpackage : ics_pkg

// ### verilog/ics_clock_unit.sv
// internal clock source unit: mode decode, reference models, switching
// Notes on behaviour
// - seven operating modes including stop
// - reset mode: loop engaged, internal reference
// - engaged external: loop output, external reference
// - bypassed internal: output internal ref, loop on
// - switch only after several new-clock cycles
// - dead new source keeps previous clock; loop on a dead ext ref still switches in
// - bus divider takes effect immediately
// - low power bit disables loop when bypassed
// - internal ref output enable drives aux clock
// - larger trim code lowers internal frequency
// - trim affects output only internal modes
// - trim values survive every reset
// - keepalive plus output enable runs ref in stop
// - external ref accepted, optional aux output
// - internal select keeps external ref off loop
`timescale 1ns/100ps
`include "ics_params.svh"
module ics_clock_unit #(
    parameter int SWITCH_TIMEOUT_CYC = `ICS_SWITCH_TIMEOUT_CYC
) (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] clock_source_select,
    input  wire logic       internal_ref_select,
    input  wire logic       loop_power_down,
    input  wire logic [1:0] bus_clock_divider,
    input  wire logic       internal_ref_output_enable,
    input  wire logic       internal_ref_stop_keepalive,
    input  wire logic       external_ref_output_enable,
    input  wire logic       stop_request,
    input  wire logic       trim_write,
    input  wire logic [7:0] trim_coarse_value,
    input  wire logic       fine_period_adjust,
    input  wire logic       external_ref_pin,
    output logic            main_clock_output,
    output logic            debug_controller_clock,
    output logic            internal_ref_aux_clock,
    output logic            external_ref_aux_clock,
    output logic            loop_enabled,
    output logic [1:0]      active_source,
    output logic [2:0]      current_mode
);
    ics_pkg::ics_mode_type   mode;
    ics_pkg::ics_src_type    want_src;
    ics_pkg::ics_levels_type lvl;

    logic [7:0]  trim_q, trim_d;
    logic        fine_q, fine_d;
    logic        ext_s1_q, ext_s2_q, ext_s3_q;
    logic [9:0]  irc_half, loop_half;
    logic [9:0]  irc_cnt_q, irc_cnt_d, loop_cnt_q, loop_cnt_d;
    logic        irc_q, irc_d, loop_q, loop_d;
    logic        irc_run, loop_run, loop_ref_ok;
    logic        rise_want;
    logic [1:0]  cur_q, cur_d;
    logic [1:0]  want_q, sel_q;
    logic [2:0]  edge_cnt_q, edge_cnt_d;
    logic [15:0] wait_q, wait_d;
    logic        src_lvl, src_lvl_q, src_rise;
    logic [2:0]  bus_clock_divider_cnt_q, bus_clock_divider_cnt_d;
    logic        main_d, dbg_d, iaux_d, eaux_d;
    logic [2:0]  bus_clock_divider_sel;

    // mode decode from select field, internal select and low power
    always_comb begin
        if (stop_request) begin
            mode = ics_pkg::STOP_MODE;
        end else begin
            case (clock_source_select)
                `ICS_SEL_INT:
                    mode = loop_power_down
                         ? ics_pkg::BYPASSED_INTERNAL_LOW_POWER_MODE
                         : ics_pkg::LOOP_BYPASSED_INTERNAL_MODE;
                `ICS_SEL_EXT:
                    mode = loop_power_down
                         ? ics_pkg::BYPASSED_EXTERNAL_LOW_POWER_MODE
                         : ics_pkg::LOOP_BYPASSED_EXTERNAL_MODE;
                default:
                    mode = internal_ref_select
                         ? ics_pkg::LOOP_ENGAGED_INTERNAL_MODE
                         : ics_pkg::LOOP_ENGAGED_EXTERNAL_MODE;
            endcase
        end
    end

    // source wanted by the mode, and which references run
    always_comb begin
        case (mode)
            ics_pkg::LOOP_BYPASSED_INTERNAL_MODE,
            ics_pkg::BYPASSED_INTERNAL_LOW_POWER_MODE:
                want_src = ics_pkg::SRC_INT;
            ics_pkg::LOOP_BYPASSED_EXTERNAL_MODE,
            ics_pkg::BYPASSED_EXTERNAL_LOW_POWER_MODE:
                want_src = ics_pkg::SRC_EXT;
            default:
                want_src = ics_pkg::SRC_LOOP;
        endcase
        // loop off in stop and in low-power bypassed modes
        loop_run = (mode != ics_pkg::STOP_MODE)
                && (mode != ics_pkg::BYPASSED_INTERNAL_LOW_POWER_MODE)
                && (mode != ics_pkg::BYPASSED_EXTERNAL_LOW_POWER_MODE);
        irc_run  = (mode != ics_pkg::STOP_MODE)
                || (internal_ref_stop_keepalive
                    && internal_ref_output_enable);
    end

    // trim register, deliberately outside the reset
    always_comb begin
        trim_d = trim_write ? trim_coarse_value : trim_q;
        fine_d = trim_write ? fine_period_adjust : fine_q;
    end

    always_ff @(posedge sys_clk) begin
        trim_q <= trim_d;
        fine_q <= fine_d;
    end

    // half periods: internal from trim, loop from its reference
    always_comb begin
        irc_half = `ICS_IRC_BASE_HALF + {1'b0, trim_q, fine_q};
        if (internal_ref_select) begin
            loop_half = irc_half >> `ICS_LOOP_SHIFT;
            loop_ref_ok = 1'b1;
        end else begin
            loop_half = `ICS_LOOP_EXT_HALF;
            loop_ref_ok = (wait_q != 16'h0000) || lvl.ext_lvl
                       || ext_s3_q; // loop waits on ext activity unless a switch is pending
        end
        if (loop_half < `ICS_HALF_MIN) begin
            loop_half = `ICS_HALF_MIN;
        end
    end

    // reference oscillator and loop output models
    always_comb begin
        irc_cnt_d = irc_cnt_q;
        irc_d     = irc_q;
        if (!irc_run) begin
            irc_cnt_d = 10'h000;
            irc_d     = 1'b0;
        end else if (irc_cnt_q + 10'h001 >= irc_half) begin
            irc_cnt_d = 10'h000;
            irc_d     = !irc_q;
        end else begin
            irc_cnt_d = irc_cnt_q + 10'h001;
        end
        loop_cnt_d = loop_cnt_q;
        loop_d     = loop_q;
        if (!loop_run || !loop_ref_ok) begin
            loop_cnt_d = 10'h000;
            loop_d     = 1'b0;
        end else if (loop_cnt_q + 10'h001 >= loop_half) begin
            loop_cnt_d = 10'h000;
            loop_d     = !loop_q;
        end else begin
            loop_cnt_d = loop_cnt_q + 10'h001;
        end
        lvl.loop_lvl = loop_q;
        lvl.int_lvl  = irc_q;
        lvl.ext_lvl  = ext_s2_q;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irc_cnt_q  <= 10'h000;
            irc_q      <= 1'b0;
            loop_cnt_q <= 10'h000;
            loop_q     <= 1'b0;
            ext_s1_q   <= 1'b0;
            ext_s2_q   <= 1'b0;
            ext_s3_q   <= 1'b0;
        end else begin
            irc_cnt_q  <= irc_cnt_d;
            irc_q      <= irc_d;
            loop_cnt_q <= loop_cnt_d;
            loop_q     <= loop_d;
            ext_s1_q   <= external_ref_pin;
            ext_s2_q   <= ext_s1_q;
            ext_s3_q   <= ext_s2_q;
        end
    end

    // switch over after several edges of the new clock, else stay
    always_comb begin
        // level of the source now on the output
        case (cur_q)
            `ICS_SEL_INT: src_lvl = lvl.int_lvl;
            `ICS_SEL_EXT: src_lvl = lvl.ext_lvl;
            default:      src_lvl = lvl.loop_lvl;
        endcase
        case (want_src)
            ics_pkg::SRC_INT: rise_want = irc_d && !irc_q;
            ics_pkg::SRC_EXT: rise_want = ext_s2_q && !ext_s3_q;
            default:          rise_want = loop_d && !loop_q;
        endcase
        cur_d      = cur_q;
        edge_cnt_d = edge_cnt_q;
        wait_d     = wait_q;
        if (want_src == cur_q) begin
            edge_cnt_d = 3'h0;
            wait_d     = 16'h0000;
        end else if (want_src != want_q
                     || clock_source_select != sel_q) begin
            edge_cnt_d = 3'h0; // new request restarts the count
            wait_d     = 16'h0000;
        end else if (wait_q >= 16'(SWITCH_TIMEOUT_CYC)) begin
            edge_cnt_d = 3'h0;
            wait_d     = 16'h0000;
        end else if (edge_cnt_q >= `ICS_SWITCH_EDGES && !src_lvl
                     && !rise_want) begin
            cur_d      = want_src;
            edge_cnt_d = 3'h0;
            wait_d     = 16'h0000;
        end else begin
            wait_d = wait_q + 16'h0001;
            if (rise_want && edge_cnt_q < `ICS_SWITCH_EDGES) begin
                edge_cnt_d = edge_cnt_q + 3'h1;
            end
        end
    end

    // bus divider on the selected source, outputs registered
    always_comb begin
        src_rise   = src_lvl && !src_lvl_q;
        bus_clock_divider_cnt_d = src_rise ? bus_clock_divider_cnt_q + 3'h1 : bus_clock_divider_cnt_q;
        case (bus_clock_divider)
            2'h1:    bus_clock_divider_sel = {2'h0, bus_clock_divider_cnt_q[0]};
            2'h2:    bus_clock_divider_sel = {2'h0, bus_clock_divider_cnt_q[1]};
            2'h3:    bus_clock_divider_sel = {2'h0, bus_clock_divider_cnt_q[2]};
            default: bus_clock_divider_sel = {2'h0, src_lvl};
        endcase
        main_d = (mode != ics_pkg::STOP_MODE) && bus_clock_divider_sel[0];
        dbg_d  = lvl.loop_lvl;
        iaux_d = internal_ref_output_enable && lvl.int_lvl;
        eaux_d = external_ref_output_enable && lvl.ext_lvl;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_q                  <= `ICS_SEL_LOOP;
            want_q                 <= `ICS_SEL_LOOP;
            sel_q                  <= `ICS_SEL_LOOP;
            edge_cnt_q             <= 3'h0;
            wait_q                 <= 16'h0000;
            src_lvl_q              <= 1'b0;
            bus_clock_divider_cnt_q             <= 3'h0;
            main_clock_output      <= 1'b0;
            debug_controller_clock <= 1'b0;
            internal_ref_aux_clock <= 1'b0;
            external_ref_aux_clock <= 1'b0;
            loop_enabled           <= 1'b0;
            active_source          <= `ICS_SEL_LOOP;
            current_mode           <= 3'h0;
        end else begin
            cur_q                  <= cur_d;
            want_q                 <= want_src;
            sel_q                  <= clock_source_select;
            edge_cnt_q             <= edge_cnt_d;
            wait_q                 <= wait_d;
            src_lvl_q              <= src_lvl;
            bus_clock_divider_cnt_q             <= bus_clock_divider_cnt_d;
            main_clock_output      <= main_d;
            debug_controller_clock <= dbg_d;
            internal_ref_aux_clock <= iaux_d;
            external_ref_aux_clock <= eaux_d;
            loop_enabled           <= loop_run;
            active_source          <= cur_q;
            current_mode           <= mode;
        end
    end
endmodule : ics_clock_unit

// ### tb/icu_clock_unit_chk.sv
// port assertions for the clock unit
`timescale 1ns/100ps
module icu_clock_unit_chk (
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic [1:0] clock_source_select,
    input wire logic       internal_ref_select,
    input wire logic       loop_power_down,
    input wire logic       internal_ref_output_enable,
    input wire logic       external_ref_output_enable,
    input wire logic       stop_request,
    input wire logic       debug_controller_clock,
    input wire logic       internal_ref_aux_clock,
    input wire logic       external_ref_aux_clock,
    input wire logic       loop_enabled,
    input wire logic [1:0] active_source,
    input wire logic [2:0] current_mode
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // mode decode, one cycle after the inputs
    a_mode_eng_int: assert property (!stop_request &&
        clock_source_select == 2'h0 && internal_ref_select
        |=> current_mode == 3'h0) else $error("engaged int mode wrong");
    a_mode_eng_ext: assert property (!stop_request &&
        clock_source_select == 2'h0 && !internal_ref_select
        |=> current_mode == 3'h1) else $error("engaged ext mode wrong");
    a_mode_byp_int: assert property (!stop_request &&
        clock_source_select == 2'h1 && !loop_power_down
        |=> current_mode == 3'h2 && loop_enabled)
        else $error("bypass int mode wrong");
    a_mode_low_pwr: assert property (!stop_request &&
        clock_source_select == 2'h2 && loop_power_down
        |=> current_mode == 3'h5 && !loop_enabled)
        else $error("ext low power mode wrong");
    a_mode_stop: assert property (stop_request
        |=> current_mode == 3'h6 && !loop_enabled)
        else $error("stop mode wrong");
    // aux clocks quiet while disabled
    a_int_aux_off: assert property (
        !internal_ref_output_enable [*3] |-> !internal_ref_aux_clock)
        else $error("internal aux runs while disabled");
    a_ext_aux_off: assert property (
        !external_ref_output_enable [*3] |-> !external_ref_aux_clock)
        else $error("external aux runs while disabled");
    // a source switch only follows a steady request
    a_switch_steady: assert property ($changed(active_source)
        |-> $past(clock_source_select, 2) == $past(clock_source_select)
        && active_source != 2'h3) else $error("unsteady source switch");
    a_debug_quiet: assert property (
        !loop_enabled [*3] |-> !debug_controller_clock)
        else $error("debug clock runs with loop off");
endmodule : icu_clock_unit_chk
bind ics_clock_unit icu_clock_unit_chk chk (.*);

// ### tb/icu_ext_ref_model.sv
// external reference oscillator feeding the clock unit
`timescale 1ns/100ps
module icu_ext_ref_model #(
    parameter int HALF_NS = 40
) (
    input  wire logic run,
    output logic      pin
);
    // stands still while stopped, scaled reference rate
    initial begin
        pin = 1'b0;
        forever begin
            #(HALF_NS);
            if (run) pin = ~pin;
        end
    end
endmodule : icu_ext_ref_model

// ### tb/internal_clock_source_unit_test.sv
// self-checking bench for the clock unit
`timescale 1ns/100ps
`include "ics_params.svh"
module internal_clock_source_unit_test;
    logic sys_clk, rst_n, internal_ref_select, loop_power_down, stop_request;
    logic internal_ref_output_enable, internal_ref_stop_keepalive;
    logic external_ref_output_enable, trim_write, fine_period_adjust;
    logic external_ref_pin, ext_run, main_clock_output, loop_enabled;
    logic debug_controller_clock, internal_ref_aux_clock;
    logic external_ref_aux_clock;
    logic [1:0] clock_source_select, bus_clock_divider, active_source;
    logic [2:0] current_mode;
    logic [7:0] trim_coarse_value;
    int fails = 0, tests_run = 0, c, k;
    wire [2:0] lv = {main_clock_output, internal_ref_aux_clock,
                     external_ref_aux_clock};
    // clock and watchdog
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial begin
        #300000;
        fails++;
        tally_and_finish;
    end
    icu_ext_ref_model #(.HALF_NS(40)) ext (.run(ext_run),
        .pin(external_ref_pin));
    ics_clock_unit #(.SWITCH_TIMEOUT_CYC(2000)) dut (.*);
    // compare and count
    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %0t seen %0h want %0h", $time, seen, exp);
        end
    endtask : check
    task tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : tally_and_finish
    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc
    // toggles of one observed clock over n cycles
    task count(input int b, input int n);
        logic [2:0] p;
        c = 0;
        p = lv;
        repeat (n) begin
            cyc(1);
            c += int'(lv[b] != p[b]);
            p = lv;
        end
    endtask : count
    task trim(input logic [7:0] v);
        @(posedge sys_clk);
        trim_write <= 1'b1;
        trim_coarse_value <= v;
        fine_period_adjust <= 1'b0;
        @(posedge sys_clk);
        trim_write <= 1'b0;
        cyc(600);
    endtask : trim
    task wait_src(input logic [1:0] s);
        k = 0;
        while (active_source !== s && k < 3000) begin
            cyc(1);
            k++;
        end
        check(active_source, s);
    endtask : wait_src
    function logic [31:0] near(input int v, input int e);
        return 32'(v + 1 >= e && v <= e + 1);
    endfunction : near
    function int half(input int v);
        return int'(`ICS_IRC_BASE_HALF) + 2 * v;
    endfunction : half
    function logic [2:0] emode(input logic [4:0] r);
        if (r[4]) return 3'h6;
        if (r[1:0] == 2'h1) return r[3] ? 3'h3 : 3'h2;
        if (r[1:0] == 2'h2) return r[3] ? 3'h5 : 3'h4;
        return r[2] ? 3'h0 : 3'h1;
    endfunction : emode
    // main sequence
    initial begin
        {rst_n, clock_source_select, loop_power_down, stop_request} = 0;
        {bus_clock_divider, internal_ref_output_enable, trim_write} = 0;
        {internal_ref_stop_keepalive, external_ref_output_enable} = 0;
        {trim_coarse_value, fine_period_adjust, ext_run} = 0;
        internal_ref_select = 1'b1;
        k = $urandom(31);
        cyc(6);
        rst_n <= 1'b1;
        trim(8'h00);
        for (int i = 0; i < 40; i++) begin
            @(posedge sys_clk);
            {stop_request, loop_power_down, internal_ref_select,
             clock_source_select} <= 5'($urandom);
            cyc(2);
            check(current_mode, emode({stop_request, loop_power_down,
                internal_ref_select, clock_source_select}));
        end
        @(posedge sys_clk);
        {stop_request, loop_power_down, clock_source_select} <= 0;
        internal_ref_select <= 1'b1;
        wait_src(2'h0);
        count(1, 300);
        check(c, 0);
        internal_ref_output_enable <= 1'b1;
        cyc(2);
        count(1, 1000);
        check(near(c, 1000 / half(0)), 1);
        trim(8'h40);
        count(1, 1000);
        check(near(c, 1000 / half(64)), 1);
        trim(8'h00);
        stop_request <= 1'b1;
        cyc(300);
        count(1, 300);
        check(c, 0);
        internal_ref_stop_keepalive <= 1'b1;
        cyc(5);
        count(1, 1000);
        check(c != 0, 1);
        {stop_request, internal_ref_stop_keepalive} <= 0;
        {external_ref_output_enable, ext_run} <= 2'h3;
        cyc(10);
        count(0, 400);
        check(near(c, 50), 1);
        ext_run <= 1'b0;
        clock_source_select <= 2'h2;
        cyc(3000);
        check(active_source, 2'h0);
        ext_run <= 1'b1;
        wait_src(2'h2);
        check(k >= 32, 1);
        clock_source_select <= 2'h1;
        wait_src(2'h1);
        count(2, 4096);
        check(near(c, 4096 / half(0)), 1);
        bus_clock_divider <= 2'h3;
        cyc(2);
        count(2, 4096);
        check(near(c, 4096 / half(0) / 8), 1);
        trim(8'h40);
        count(2, 4096);
        check(near(c, 4096 / half(64) / 8), 1);
        // reset in mid-run: outputs clear, trim survives
        @(posedge sys_clk);
        rst_n <= 1'b0;
        cyc(2);
        check(lv, 3'h0);
        check(active_source, 2'h0);
        @(posedge sys_clk);
        rst_n <= 1'b1;
        count(1, 1000);
        check(near(c, 1000 / half(64)), 1);
        tally_and_finish;
    end
endmodule : internal_clock_source_unit_test
